/* File: ffx_nvm_wait.sv */
`timescale 1ns/100ps
package ffx_pkg;
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;
  // register byte offsets
  localparam logic [WB_AW-1:0] OFS_OP = 8'h00;
  localparam logic [WB_AW-1:0] OFS_FLAGS = 8'h04;
  localparam logic [WB_AW-1:0] OFS_INFO = 8'h08;
  // op register fields
  localparam int OP_CODE_LSB = 0;
  localparam int OP_NVM_BIT = 4;
  localparam int OP_BASE_LSB = 5;
  // info register fields
  localparam int INFO_BUSY_BIT = 0;
  localparam int INFO_BRK_BIT = 1;
  localparam int INFO_REF_BIT = 2;
  localparam int INFO_CNT_LSB = 8;
  // status flag positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [2:0] BASE_MIN = 3'h1;
  typedef enum logic [3:0] {
    OPC_NOP = 4'h0, OPC_SGN_SET = 4'h1, OPC_SGN_CLR = 4'h2,
    OPC_OVF_SET = 4'h3, OPC_OVF_CLR = 4'h4, OPC_HC_SET = 4'h5,
    OPC_HC_CLR = 4'h6, OPC_IRQ_EN = 4'h7, OPC_IRQ_DIS = 4'h8,
    OPC_T_SET = 4'h9, OPC_T_CLR = 4'hA, OPC_Z_CLR = 4'hB,
    OPC_BRK = 4'hC, OPC_MEM = 4'hD
  } ffx_opc_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [WB_AW-1:0] adr;
    logic [WB_DW-1:0] dat;
  } ffx_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [WB_DW-1:0] dat;
  } ffx_wb_rsp_t;
endpackage : ffx_pkg

module ffx_nvm_wait
  import ffx_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // access request
  input wire logic start_i,
  input wire logic nvm_i,
  input wire logic [2:0] base_i,
  // controller handshake
  input wire logic nvm_grant_i,
  // result
  output logic busy_o,
  output logic waiting_o,
  output logic done_o,
  output logic [7:0] elapsed_o
);
  typedef struct packed {
    logic busy;
    logic wait_g;
    logic nvm;
    logic [2:0] base;
    logic [7:0] cnt;
    logic done;
    logic [7:0] elapsed;
  } ffx_nw_st_t;

  ffx_nw_st_t st_q, st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.done = 1'b0;
    if (!st_q.busy)
    begin
      if (start_i)
      begin
        st_d.busy = 1'b1;
        st_d.wait_g = 1'b0;
        st_d.nvm = nvm_i;
        st_d.base = (base_i < BASE_MIN) ? BASE_MIN : base_i;
        st_d.cnt = 8'h01;
      end
    end
    else if (!st_q.wait_g)
    begin
      if (st_q.cnt >= {5'h00, st_q.base})
      begin
        if (st_q.nvm)
        begin
          // the controller always costs a cycle beyond the ram timing
          st_d.wait_g = 1'b1;
          st_d.cnt = st_q.cnt + 8'h01;
        end
        else
        begin
          st_d.busy = 1'b0;
          st_d.done = 1'b1;
          st_d.elapsed = st_q.cnt;
        end
      end
      else
      begin
        st_d.cnt = st_q.cnt + 8'h01;
      end
    end
    else if (nvm_grant_i)
    begin
      st_d.busy = 1'b0;
      st_d.wait_g = 1'b0;
      st_d.done = 1'b1;
      st_d.elapsed = st_q.cnt;
    end
    else if (st_q.cnt != CNT_MAX)
    begin
      // count saturates; a very long stall still finishes correctly
      st_d.cnt = st_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign busy_o = st_q.busy;
  assign waiting_o = st_q.wait_g;
  assign done_o = st_q.done;
  assign elapsed_o = st_q.elapsed;

  property p_nvm_extra;
    @(posedge core_clk_i) disable iff (!nrst_i)
    st_q.busy && st_q.nvm && !st_q.wait_g && st_q.cnt >= {5'h00, st_q.base}
    |=> !done_o && waiting_o;
  endproperty
  a_nvm_extra: assert property (p_nvm_extra)
    else $error("nvm access finished without its extra cycle");

  property p_stall;
    @(posedge core_clk_i) disable iff (!nrst_i)
    waiting_o && !nvm_grant_i |=> busy_o && !done_o;
  endproperty
  a_stall: assert property (p_stall)
    else $error("nvm access ended before the grant");

  property p_grant_done;
    @(posedge core_clk_i) disable iff (!nrst_i)
    waiting_o && nvm_grant_i |=> done_o && !busy_o && elapsed_o > 8'h01;
  endproperty
  a_grant_done: assert property (p_grant_done)
    else $error("grant did not end the nvm access");
endmodule : ffx_nvm_wait

/* File: ffx_flag_exec.sv */
// Functional notes
// - signed flag set/clear forces only S to 1/0 in one cycle.
// - overflow set/clear forces only V to 1/0 in one cycle.
// - half-carry set/clear forces only H to 1/0 in one cycle.
// - break takes one cycle, changes no flag, signals debug logic.
// - nvm-controller access takes at least one cycle beyond ram timing.
// - nvm access stalls further until the controller grants it.
//
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
module ffx_flag_exec
  import ffx_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // wishbone slave
  input wire ffx_pkg::ffx_wb_req_t wb_req_i,
  output ffx_pkg::ffx_wb_rsp_t wb_rsp_o,
  // nonvolatile memory controller
  input wire logic nvm_grant_i,
  // core side
  output logic [7:0] status_flag_reg_o,
  output logic debug_break_o,
  output logic mem_done_o
);
  import ffx_pkg::*;

  typedef struct packed {
    logic ack;
    logic [WB_DW-1:0] dat;
    logic [7:0] flags;
    logic brk;
    logic brk_seen;
    logic refused;
  } ffx_top_st_t;

  ffx_top_st_t st_q, st_d;

  logic mem_busy;
  logic mem_waiting;
  logic [7:0] mem_elapsed;
  logic wr_hit;
  logic fire;
  logic mem_start;
  ffx_opc_t op_code;

  function automatic logic reg_sel(input logic [WB_AW-1:0] adr,
                                   input logic [WB_AW-1:0] ofs);
    reg_sel = (adr[WB_AW-1:2] == ofs[WB_AW-1:2]);
  endfunction : reg_sel

  // each flag op touches exactly one bit; anything else leaves flags alone
  function automatic logic [7:0] flag_apply(input ffx_opc_t code,
                                            input logic [7:0] s);
    logic [7:0] r;
    r = s;
    unique case (code)
      OPC_SGN_SET: r[FLG_S] = 1'b1;
      OPC_SGN_CLR: r[FLG_S] = 1'b0;
      OPC_OVF_SET: r[FLG_V] = 1'b1;
      OPC_OVF_CLR: r[FLG_V] = 1'b0;
      OPC_HC_SET: r[FLG_H] = 1'b1;
      OPC_HC_CLR: r[FLG_H] = 1'b0;
      OPC_IRQ_EN: r[FLG_I] = 1'b1;
      OPC_IRQ_DIS: r[FLG_I] = 1'b0;
      OPC_T_SET: r[FLG_T] = 1'b1;
      OPC_T_CLR: r[FLG_T] = 1'b0;
      OPC_Z_CLR: r[FLG_Z] = 1'b0;
      default: r = s;
    endcase
    flag_apply = r;
  endfunction : flag_apply

  // writes take effect at the edge where ack is seen high
  assign wr_hit = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && st_q.ack
                  && wb_req_i.sel[0];
  assign op_code = ffx_opc_t'(wb_req_i.dat[OP_CODE_LSB +: 4]);
  // one instruction at a time: ops issued during a memory access are dropped
  assign fire = wr_hit && reg_sel(wb_req_i.adr, OFS_OP) && !mem_busy;
  assign mem_start = fire && op_code == OPC_MEM;

  always_comb
  begin
    st_d = st_q;
    st_d.brk = 1'b0;
    st_d.ack = wb_req_i.cyc && wb_req_i.stb && !st_q.ack;
    st_d.dat = '0;
    if (wb_req_i.cyc && wb_req_i.stb && !st_q.ack && !wb_req_i.we)
    begin
      if (reg_sel(wb_req_i.adr, OFS_FLAGS))
        st_d.dat[7:0] = st_q.flags;
      else if (reg_sel(wb_req_i.adr, OFS_INFO))
      begin
        st_d.dat[INFO_BUSY_BIT] = mem_busy;
        st_d.dat[INFO_BRK_BIT] = st_q.brk_seen;
        st_d.dat[INFO_REF_BIT] = st_q.refused;
        st_d.dat[INFO_CNT_LSB +: 8] = mem_elapsed;
      end
    end
    if (wr_hit && reg_sel(wb_req_i.adr, OFS_FLAGS))
      st_d.flags = wb_req_i.dat[7:0];
    if (wr_hit && reg_sel(wb_req_i.adr, OFS_INFO))
    begin
      if (wb_req_i.dat[INFO_BRK_BIT])
        st_d.brk_seen = 1'b0;
      if (wb_req_i.dat[INFO_REF_BIT])
        st_d.refused = 1'b0;
    end
    if (wr_hit && reg_sel(wb_req_i.adr, OFS_OP) && mem_busy)
      st_d.refused = 1'b1;
    if (fire)
    begin
      st_d.flags = flag_apply(op_code, st_q.flags);
      if (op_code == OPC_BRK)
      begin
        // break leaves every flag alone and hands over to debug
        st_d.brk = 1'b1;
        st_d.brk_seen = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_q <= '0;
      st_q.flags <= FLAGS_RST;
    end
    else
      st_q <= st_d;
  end

  ffx_nvm_wait u_nvm_wait (
    .core_clk_i (core_clk_i),
    .nrst_i (nrst_i),
    .start_i (mem_start),
    .nvm_i (wb_req_i.dat[OP_NVM_BIT]),
    .base_i (wb_req_i.dat[OP_BASE_LSB +: 3]),
    .nvm_grant_i (nvm_grant_i),
    .busy_o (mem_busy),
    .waiting_o (mem_waiting),
    .done_o (mem_done_o),
    .elapsed_o (mem_elapsed)
  );

  assign wb_rsp_o.ack = st_q.ack;
  assign wb_rsp_o.dat = st_q.dat;
  assign status_flag_reg_o = st_q.flags;
  assign debug_break_o = st_q.brk;

  // only the target bit may move; every other flag keeps its old value
  sequence s_flag_only(int b, logic v);
    st_q.flags[b] == v
    && ((st_q.flags ^ $past(st_q.flags)) & ~(8'h01 << b)) == 8'h00;
  endsequence
  sequence s_op_fired(logic [3:0] code);
    fire && op_code == code;
  endsequence

  property p_sgn_set;
    @(posedge core_clk_i) disable iff (!nrst_i)
    s_op_fired(OPC_SGN_SET) |=> s_flag_only(FLG_S, 1'b1);
  endproperty
  a_sgn_set: assert property (p_sgn_set)
    else $error("signed flag set failed");
  property p_sgn_clr;
    @(posedge core_clk_i) disable iff (!nrst_i)
    s_op_fired(OPC_SGN_CLR) |=> s_flag_only(FLG_S, 1'b0);
  endproperty
  a_sgn_clr: assert property (p_sgn_clr)
    else $error("signed flag clear failed");
  property p_ovf_set;
    @(posedge core_clk_i) disable iff (!nrst_i)
    s_op_fired(OPC_OVF_SET) |=> s_flag_only(FLG_V, 1'b1);
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow flag set failed");
  property p_ovf_clr;
    @(posedge core_clk_i) disable iff (!nrst_i)
    s_op_fired(OPC_OVF_CLR) |=> s_flag_only(FLG_V, 1'b0);
  endproperty
  a_ovf_clr: assert property (p_ovf_clr)
    else $error("overflow flag clear failed");
  property p_hc_set;
    @(posedge core_clk_i) disable iff (!nrst_i)
    s_op_fired(OPC_HC_SET) |=> s_flag_only(FLG_H, 1'b1);
  endproperty
  a_hc_set: assert property (p_hc_set)
    else $error("half carry set failed");
  property p_hc_clr;
    @(posedge core_clk_i) disable iff (!nrst_i)
    s_op_fired(OPC_HC_CLR) |=> s_flag_only(FLG_H, 1'b0);
  endproperty
  a_hc_clr: assert property (p_hc_clr)
    else $error("half carry clear failed");
  property p_irq_en;
    @(posedge core_clk_i) disable iff (!nrst_i)
    s_op_fired(OPC_IRQ_EN) |=> s_flag_only(FLG_I, 1'b1);
  endproperty
  a_irq_en: assert property (p_irq_en)
    else $error("interrupt enable failed");
  property p_irq_dis;
    @(posedge core_clk_i) disable iff (!nrst_i)
    s_op_fired(OPC_IRQ_DIS) |=> s_flag_only(FLG_I, 1'b0);
  endproperty
  a_irq_dis: assert property (p_irq_dis)
    else $error("interrupt disable failed");
  property p_t_set;
    @(posedge core_clk_i) disable iff (!nrst_i)
    s_op_fired(OPC_T_SET) |=> s_flag_only(FLG_T, 1'b1);
  endproperty
  a_t_set: assert property (p_t_set)
    else $error("transfer bit set failed");
  property p_t_clr;
    @(posedge core_clk_i) disable iff (!nrst_i)
    s_op_fired(OPC_T_CLR) |=> s_flag_only(FLG_T, 1'b0);
  endproperty
  a_t_clr: assert property (p_t_clr)
    else $error("transfer bit clear failed");
  property p_z_clr;
    @(posedge core_clk_i) disable iff (!nrst_i)
    s_op_fired(OPC_Z_CLR) |=> s_flag_only(FLG_Z, 1'b0);
  endproperty
  a_z_clr: assert property (p_z_clr)
    else $error("zero flag clear failed");

  sequence s_break_issued;
    fire && op_code == OPC_BRK;
  endsequence
  sequence s_break_done;
    debug_break_o && st_q.flags == $past(st_q.flags) ##1 !debug_break_o;
  endsequence
  property p_break;
    @(posedge core_clk_i) disable iff (!nrst_i)
    s_break_issued |=> s_break_done;
  endproperty
  a_break: assert property (p_break)
    else $error("break changed flags or did not pulse once");

  property p_nvm_min;
    @(posedge core_clk_i) disable iff (!nrst_i)
    mem_start && wb_req_i.dat[OP_NVM_BIT] && !nvm_grant_i
    |=> mem_busy [*2];
  endproperty
  a_nvm_min: assert property (p_nvm_min)
    else $error("nvm access shorter than two cycles");

  sequence s_bus_req;
    wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  endsequence
  // ack must drop after one cycle even if the master keeps its request up
  property p_ack_pulse;
    @(posedge core_clk_i) disable iff (!nrst_i)
    s_bus_req |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("bus ack was not a single-cycle pulse");
endmodule : ffx_flag_exec

/* File: flag_and_control_insn_exec_tb.sv */
`timescale 1ns/100ps
module flag_and_control_insn_exec_tb;
  import ffx_pkg::*;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  ffx_wb_req_t req = '0;
  ffx_wb_rsp_t rsp;
  logic grant = 1'b0;
  logic [7:0] flags;
  logic brk;
  logic done;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed = 32'h02CA;
  logic [31:0] rd;
  logic [7:0] s;
  logic [3:0] op;
  logic [2:0] b;
  logic nvm;
  int n;
  int d;
  int bb;

  ffx_flag_exec uut (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .wb_req_i(req),
    .wb_rsp_o(rsp),
    .nvm_grant_i(grant),
    .status_flag_reg_o(flags),
    .debug_break_o(brk),
    .mem_done_o(done)
  );

  initial
  begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  task print_verdict;
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // ceiling sits well above the fewer than a thousand cycles the sequence needs
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      $display("unexpected timeout: expected end, seen hang");
      print_verdict();
    end
  end

  task check(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask : check

  // one classic cycle; ack is sampled on the edge, never after it
  task wb(input logic we, input logic [7:0] a, input logic [31:0] dt);
    @(posedge core_clk_i);
    // fields in struct order: cyc, stb, we, sel, adr, dat
    req <= {1'b1, 1'b1, we, 4'hF, a, dt};
    forever
    begin
      @(posedge core_clk_i);
      if (rsp.ack === 1'b1)
        break;
    end
    rd = rsp.dat;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask : wb

  function logic [7:0] expf(input logic [7:0] v, input logic [3:0] c);
    expf = v;
    case (c)
      4'h1: expf[FLG_S] = 1'b1;
      4'h2: expf[FLG_S] = 1'b0;
      4'h3: expf[FLG_V] = 1'b1;
      4'h4: expf[FLG_V] = 1'b0;
      4'h5: expf[FLG_H] = 1'b1;
      4'h6: expf[FLG_H] = 1'b0;
      4'h7: expf[FLG_I] = 1'b1;
      4'h8: expf[FLG_I] = 1'b0;
      4'h9: expf[FLG_T] = 1'b1;
      4'hA: expf[FLG_T] = 1'b0;
      4'hB: expf[FLG_Z] = 1'b0;
      default: ;
    endcase
  endfunction : expf

  task mem_wait;
    n = 0;
    while (n < 600)
    begin
      @(posedge core_clk_i);
      if (done === 1'b1)
        break;
      n++;
      if (nvm && n == bb + d)
        grant <= 1'b1;
    end
    grant <= 1'b0;
  endtask : mem_wait

  initial
  begin
    repeat (4) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    #1;
    check("flags after reset", {24'h0, FLAGS_RST}, {24'h0, flags});
    // every code except D once, then random codes 0 to C on random flag patterns
    for (int i = 0; i < 48; i++)
    begin
      s = 8'($random(seed));
      // codes E and F are spare and must behave as no-operations
      op = (i < 13) ? 4'(i) : (i < 15) ? 4'(i + 1)
           : 4'($unsigned($random(seed)) % 13);
      wb(1'b1, OFS_FLAGS, {24'h0, s});
      grant <= 1'($random(seed));
      wb(1'b1, OFS_OP, {28'h0, op});
      #1;
      check("break pulse", {31'h0, op == 4'hC}, {31'h0, brk});
      check("flags", {24'h0, expf(s, op)}, {24'h0, flags});
      @(posedge core_clk_i);
      #1;
      check("break width", 32'h0, {31'h0, brk});
      wb(1'b0, OFS_FLAGS, 32'h0);
      check("flag read", {24'h0, expf(s, op)}, rd);
    end
    // ram and nvm accesses over every base count, grant held off a while
    for (int j = 0; j < 16; j++)
    begin
      b = 3'(j);
      nvm = j[3];
      bb = (b == 3'h0) ? 1 : int'(b);
      d = $unsigned($random(seed)) % 8;
      grant <= nvm ? 1'b0 : 1'($random(seed));
      wb(1'b1, OFS_OP, {24'h0, b, nvm, 4'hD});
      mem_wait();
      check("done seen", 32'h1, {31'h0, done});
      wb(1'b0, OFS_INFO, 32'h0);
      if (!nvm)
        check("ram cycles", 32'(bb), 32'(rd[15:8]));
      else
      begin
        check("nvm extra", 32'h1, {31'h0, rd[15:8] >= 8'(bb + 1)});
        check("nvm stall", 32'h1, {31'h0, n >= bb + d});
      end
    end
    // a flag op during the base count of an nvm access, before its stall, is refused and leaves flags alone
    wb(1'b1, OFS_FLAGS, 32'h0);
    nvm = 1'b1;
    bb = 7;
    d = 20;
    wb(1'b1, OFS_OP, 32'hFD);
    wb(1'b1, OFS_OP, 32'h1);
    wb(1'b0, OFS_INFO, 32'h0);
    check("busy refused", 32'h5, rd & 32'h5);
    check("break seen", 32'h2, rd & 32'h2);
    mem_wait();
    check("stall done", 32'h1, {31'h0, done});
    wb(1'b0, OFS_FLAGS, 32'h0);
    check("refused flags", 32'h0, rd);
    wb(1'b1, OFS_INFO, 32'h6);
    wb(1'b0, OFS_INFO, 32'h0);
    check("refused cleared", 32'h0, rd & 32'h7);
    wb(1'b1, 8'hFC, 32'hFF);
    wb(1'b0, 8'hFC, 32'h0);
    check("unmapped", 32'h0, rd);
    print_verdict();
  end
endmodule : flag_and_control_insn_exec_tb
